//--- cond_trap_cfg.svh
`ifndef COND_TRAP_CFG_SVH
`define COND_TRAP_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Flag register bit positions and reset value
`define FLAG_C      0
`define FLAG_V      1
`define FLAG_Z      2
`define FLAG_N      3
`define FLAG_X      4
`define FLAG_WIDTH  5
`define FLAG_RESET  5'h00

////////////////////////////////////////////////////////////////////////////////
// Condition field encodings
`define CODE_ALWAYS               4'h0
`define CODE_NEVER                4'h1
`define CODE_UNSIGNED_HIGHER      4'h2
`define CODE_LOWER_OR_SAME        4'h3
`define CODE_CARRY_CLEAR          4'h4
`define CODE_CARRY_SET            4'h5
`define CODE_NOT_EQUAL            4'h6
`define CODE_EQUAL_TEST           4'h7
`define CODE_OVERFLOW_CLEAR       4'h8
`define CODE_OVERFLOW_SET         4'h9
`define CODE_PLUS_TEST            4'ha
`define CODE_MINUS_TEST           4'hb
`define CODE_SIGNED_GREATER_EQUAL 4'hc
`define CODE_SIGNED_LESS          4'hd
`define CODE_SIGNED_GREATER       4'he
`define CODE_SIGNED_LESS_EQUAL    4'hf

////////////////////////////////////////////////////////////////////////////////
// Exception vector numbers
`define VEC_ILLEGAL     8'h04
`define VEC_BOUND       8'h06
`define VEC_COND_TRAP   8'h07
`define VEC_OVF_TRAP    8'h08
`define VEC_DEBUG       8'h09
`define VEC_SW_TRAP     8'h20

////////////////////////////////////////////////////////////////////////////////
// Stack frame
`define STACK_DEC_SHORT 32'h0000_0002
`define STACK_DEC_LONG  32'h0000_0004
`define FRAME_FORMAT    4'h0
`define SSP_RESET       32'h0000_0000

////////////////////////////////////////////////////////////////////////////////
// Instruction length increments for the next program counter
`define PC_ADV_NONE     4'h2
`define PC_ADV_WORD     4'h4
`define PC_ADV_LONG     4'h6

`endif

//--- cond_trap_pkg.sv
package cond_trap_pkg;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_COND_TEST,
        OP_BRANCH,
        OP_COND_TRAP,
        OP_OVF_TRAP,
        OP_BOUND1,
        OP_BOUND2,
        OP_BREAKPOINT_INSTR,
        OP_ENTER_DEBUG,
        OP_SW_TRAP,
        OP_AND_IMM,
        OP_XOR_IMM,
        OP_OR_IMM
    } op_kind_t;

    typedef enum logic [1:0] {
        SZ_NONE,
        SZ_BYTE,
        SZ_WORD,
        SZ_LONG
    } size_t;

    typedef enum {
        ST_IDLE,
        ST_BREAKPOINT_INSTR_WAIT,
        ST_PUSH_FV,
        ST_PUSH_PC,
        ST_PUSH_STATUS,
        ST_VECTOR
    } seq_state_t;

endpackage

//--- cond_eval.sv
`timescale 1ns/1ps
`default_nettype none
`include "cond_trap_cfg.svh"

module cond_eval (
    input  wire logic [3:0]             code,
    input  wire logic [`FLAG_WIDTH-1:0] flags,
    output logic                        cond_true
);

    logic n;
    logic z;
    logic v;
    logic c;

    assign n = flags[`FLAG_N];
    assign z = flags[`FLAG_Z];
    assign v = flags[`FLAG_V];
    assign c = flags[`FLAG_C];

    // Pure function of the flags; nothing here can write them back
    always_comb begin
        case (code)
            `CODE_ALWAYS:               cond_true = 1'b1;
            `CODE_NEVER:                cond_true = 1'b0;
            `CODE_UNSIGNED_HIGHER:      cond_true = !c && !z;
            `CODE_LOWER_OR_SAME:        cond_true = c || z;
            `CODE_CARRY_CLEAR:          cond_true = !c;
            `CODE_CARRY_SET:            cond_true = c;
            `CODE_NOT_EQUAL:            cond_true = !z;
            `CODE_EQUAL_TEST:           cond_true = z;
            `CODE_OVERFLOW_CLEAR:       cond_true = !v;
            `CODE_OVERFLOW_SET:         cond_true = v;
            `CODE_PLUS_TEST:            cond_true = !n;
            `CODE_MINUS_TEST:           cond_true = n;
            `CODE_SIGNED_GREATER_EQUAL: cond_true = (n == v);
            `CODE_SIGNED_LESS:          cond_true = (n != v);
            `CODE_SIGNED_GREATER:       cond_true = (n == v) && !z;
            `CODE_SIGNED_LESS_EQUAL:    cond_true = z || (n != v);
            default:                    cond_true = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

//--- cond_trap_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "cond_trap_cfg.svh"

module cond_trap_unit
    import cond_trap_pkg::*;
(
    input  wire logic                    REF_CLK,
    input  wire logic                    RST_N,
    input  wire logic                    OP_VALID,
    input  wire cond_trap_pkg::op_kind_t OP_KIND,
    input  wire cond_trap_pkg::size_t    OP_SIZE,
    input  wire logic [3:0]              COND_CODE,
    input  wire logic [7:0]              IMM_BYTE,
    input  wire logic [7:0]              TRAP_NUM,
    input  wire logic [31:0]             DATA_VAL,
    input  wire logic [31:0]             LOWER_BOUND,
    input  wire logic [31:0]             UPPER_BOUND,
    input  wire logic [31:0]             PC_IN,
    input  wire logic [15:0]             STATUS_WORD,
    input  wire logic                    BG_MODE_EN,
    input  wire logic                    FLAG_WE,
    input  wire logic [4:0]              FLAG_IN,
    input  wire logic                    SSP_LOAD,
    input  wire logic [31:0]             SSP_IN,
    input  wire logic                    BREAKPOINT_INSTR_ACK,
    input  wire logic                    BREAKPOINT_INSTR_NOACK,
    input  wire logic [15:0]             BREAKPOINT_INSTR_WORD,
    output logic                         BUSY,
    output logic                         BREAKPOINT_INSTR_ACK_CYCLE,
    output logic [4:0]                   FLAG_REGISTER,
    output logic [31:0]                  SUPERVISOR_STACK_POINTER,
    output logic                         COND_RESULT,
    output logic [3:0]                   PC_ADVANCE,
    output logic                         FLUSH,
    output logic                         EXC_REQ,
    output logic [7:0]                   EXC_VECTOR,
    output logic                         VECTOR_FETCH,
    output logic                         DEBUG_ENTER,
    output logic                         EXEC_WORD_VALID,
    output logic [15:0]                  EXEC_WORD,
    output logic                         STACK_WR,
    output logic                         STACK_LONG,
    output logic [31:0]                  STACK_ADDR,
    output logic [31:0]                  STACK_DATA
);

    import cond_trap_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Signals

    seq_state_t                 state_q;
    logic [`FLAG_WIDTH-1:0]     flags_q;
    logic [31:0]                ssp_q;
    logic [7:0]                 vec_q;
    logic                       take;
    logic                       cond_true;
    logic signed [31:0]         data_s;
    logic signed [31:0]         lower_s;
    logic signed [31:0]         upper_s;
    logic                       bound1_fail;
    logic                       bound2_fail;
    logic [4:0]                 imm_flags;
    size_t                      chk_sz;

    function automatic logic signed [31:0] sext(input logic [31:0] val, input size_t sz);
        case (sz)
            SZ_BYTE: sext = {{24{val[7]}}, val[7:0]};
            SZ_WORD: sext = {{16{val[15]}}, val[15:0]};
            default: sext = val;
        endcase
    endfunction

    // Ops are accepted only in idle, so a long stack sequence holds off the core
    assign BUSY           = (state_q != ST_IDLE);
    assign take           = OP_VALID && !BUSY;
    assign BREAKPOINT_INSTR_ACK_CYCLE = (state_q == ST_BREAKPOINT_INSTR_WAIT);
    assign FLAG_REGISTER  = flags_q;
    assign SUPERVISOR_STACK_POINTER = ssp_q;
    assign imm_flags      = IMM_BYTE[4:0];

    cond_eval i_cond_eval (
        .code      (COND_CODE),
        .flags     (flags_q),
        .cond_true (cond_true)
    );

    // Single check has no byte form, so a byte size is taken as word
    assign chk_sz  = (OP_KIND == OP_BOUND1 && OP_SIZE == SZ_BYTE) ? SZ_WORD : OP_SIZE;
    assign data_s  = sext(DATA_VAL, chk_sz);
    assign lower_s = sext(LOWER_BOUND, OP_SIZE);
    assign upper_s = sext(UPPER_BOUND, chk_sz);
    assign bound1_fail = (data_s < 0) || (data_s > upper_s);
    assign bound2_fail = (data_s < lower_s) || (data_s > upper_s);

    ////////////////////////////////////////////////////////////////////////////
    // Flag register

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            flags_q <= `FLAG_RESET;
        end else if (take && OP_KIND == OP_AND_IMM) begin
            flags_q <= flags_q & imm_flags;
        end else if (take && OP_KIND == OP_XOR_IMM) begin
            flags_q <= flags_q ^ imm_flags;
        end else if (take && OP_KIND == OP_OR_IMM) begin
            flags_q <= flags_q | imm_flags;
        end else if (FLAG_WE) begin
            flags_q <= FLAG_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Supervisor stack pointer

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ssp_q <= `SSP_RESET;
        end else if (state_q == ST_PUSH_FV || state_q == ST_PUSH_STATUS) begin
            ssp_q <= ssp_q - `STACK_DEC_SHORT;
        end else if (state_q == ST_PUSH_PC) begin
            ssp_q <= ssp_q - `STACK_DEC_LONG;
        end else if (SSP_LOAD) begin
            ssp_q <= SSP_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Condition result and instruction length

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            COND_RESULT <= 1'b0;
            PC_ADVANCE  <= `PC_ADV_NONE;
        end else if (take) begin
            COND_RESULT <= cond_true;
            case (OP_SIZE)
                SZ_WORD: PC_ADVANCE <= `PC_ADV_WORD;
                SZ_LONG: PC_ADVANCE <= `PC_ADV_LONG;
                default: PC_ADVANCE <= `PC_ADV_NONE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flush

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            FLUSH <= 1'b0;
        end else begin
            FLUSH <= take && OP_KIND != OP_NONE && OP_KIND != OP_COND_TEST
                     && OP_KIND != OP_BRANCH;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trap sequencer

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q         <= ST_IDLE;
            vec_q           <= 8'h00;
            EXC_REQ         <= 1'b0;
            EXC_VECTOR      <= 8'h00;
            VECTOR_FETCH    <= 1'b0;
            DEBUG_ENTER     <= 1'b0;
            EXEC_WORD_VALID <= 1'b0;
            EXEC_WORD       <= 16'h0000;
            STACK_WR        <= 1'b0;
            STACK_LONG      <= 1'b0;
            STACK_ADDR      <= 32'h0000_0000;
            STACK_DATA      <= 32'h0000_0000;
        end else begin
            EXC_REQ         <= 1'b0;
            VECTOR_FETCH    <= 1'b0;
            DEBUG_ENTER     <= 1'b0;
            EXEC_WORD_VALID <= 1'b0;
            STACK_WR        <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        case (OP_KIND)
                            OP_BRANCH: begin
                                // A never condition is not a legal branch
                                if (COND_CODE == `CODE_NEVER) begin
                                    EXC_REQ    <= 1'b1;
                                    EXC_VECTOR <= `VEC_ILLEGAL;
                                end
                            end
                            OP_COND_TRAP: begin
                                if (cond_true) begin
                                    EXC_REQ    <= 1'b1;
                                    EXC_VECTOR <= `VEC_COND_TRAP;
                                end
                            end
                            OP_OVF_TRAP: begin
                                if (flags_q[`FLAG_V]) begin
                                    EXC_REQ    <= 1'b1;
                                    EXC_VECTOR <= `VEC_OVF_TRAP;
                                end
                            end
                            OP_BOUND1, OP_BOUND2: begin
                                if (OP_KIND == OP_BOUND1 ? bound1_fail : bound2_fail) begin
                                    EXC_REQ    <= 1'b1;
                                    EXC_VECTOR <= `VEC_BOUND;
                                end
                            end
                            OP_BREAKPOINT_INSTR: begin
                                state_q <= ST_BREAKPOINT_INSTR_WAIT;
                            end
                            OP_ENTER_DEBUG: begin
                                if (BG_MODE_EN) begin
                                    DEBUG_ENTER <= 1'b1;
                                end else begin
                                    vec_q   <= `VEC_DEBUG;
                                    state_q <= ST_PUSH_FV;
                                end
                            end
                            OP_SW_TRAP: begin
                                vec_q   <= `VEC_SW_TRAP + {4'h0, TRAP_NUM[3:0]};
                                state_q <= ST_PUSH_FV;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_BREAKPOINT_INSTR_WAIT: begin
                    // Acknowledge wins if both answers arrive together
                    if (BREAKPOINT_INSTR_ACK) begin
                        EXEC_WORD_VALID <= 1'b1;
                        EXEC_WORD       <= BREAKPOINT_INSTR_WORD;
                        state_q         <= ST_IDLE;
                    end else if (BREAKPOINT_INSTR_NOACK) begin
                        EXC_REQ    <= 1'b1;
                        EXC_VECTOR <= `VEC_ILLEGAL;
                        state_q    <= ST_IDLE;
                    end
                end
                ST_PUSH_FV: begin
                    STACK_WR   <= 1'b1;
                    STACK_LONG <= 1'b0;
                    STACK_ADDR <= ssp_q - `STACK_DEC_SHORT;
                    STACK_DATA <= {16'h0000, `FRAME_FORMAT, 2'b00, vec_q, 2'b00};
                    state_q    <= ST_PUSH_PC;
                end
                ST_PUSH_PC: begin
                    STACK_WR   <= 1'b1;
                    STACK_LONG <= 1'b1;
                    STACK_ADDR <= ssp_q - `STACK_DEC_LONG;
                    STACK_DATA <= PC_IN;
                    state_q    <= ST_PUSH_STATUS;
                end
                ST_PUSH_STATUS: begin
                    STACK_WR   <= 1'b1;
                    STACK_LONG <= 1'b0;
                    STACK_ADDR <= ssp_q - `STACK_DEC_SHORT;
                    STACK_DATA <= {16'h0000, STATUS_WORD[15:5], flags_q};
                    state_q    <= ST_VECTOR;
                end
                ST_VECTOR: begin
                    VECTOR_FETCH <= 1'b1;
                    EXC_VECTOR   <= vec_q;
                    state_q      <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    AST_NEVER_FALSE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (COND_CODE == `CODE_NEVER) |-> !cond_true)
        else $error("never condition evaluated true");
    AST_EQUAL_Z: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (COND_CODE == `CODE_EQUAL_TEST) |-> (cond_true == flags_q[`FLAG_Z]))
        else $error("equal test does not follow zero flag");
    AST_SIGNED_GT: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (COND_CODE == `CODE_SIGNED_GREATER) |-> (cond_true ==
        ((flags_q[`FLAG_N] == flags_q[`FLAG_V]) && !flags_q[`FLAG_Z])))
        else $error("signed greater test wrong");
    AST_EVAL_NO_SIDE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (take && OP_KIND == OP_COND_TEST && !FLAG_WE) |=> $stable(flags_q))
        else $error("condition test altered flags");
    AST_COND_TRAP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (take && OP_KIND == OP_COND_TRAP) |=> (EXC_REQ == $past(cond_true))
        && (!EXC_REQ || EXC_VECTOR == `VEC_COND_TRAP))
        else $error("conditional trap mismatch");
    AST_OVF_TRAP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (take && OP_KIND == OP_OVF_TRAP) |=> (EXC_REQ == $past(flags_q[`FLAG_V])))
        else $error("overflow trap mismatch");
    AST_BOUND_ONE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (take && OP_KIND == OP_BOUND1 && data_s < 0) |=> EXC_REQ
        && EXC_VECTOR == `VEC_BOUND)
        else $error("negative value passed bound check");
    AST_BOUND_TWO: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (take && OP_KIND == OP_BOUND2 && data_s > upper_s) |=> EXC_REQ)
        else $error("value above upper bound passed");
    AST_BREAKPOINT_INSTR_EXEC: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (BREAKPOINT_INSTR_ACK_CYCLE && BREAKPOINT_INSTR_ACK) |=> EXEC_WORD_VALID && !EXC_REQ
        && EXEC_WORD == $past(BREAKPOINT_INSTR_WORD))
        else $error("acknowledged breakpoint word not issued");
    AST_DEBUG_ENTER: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (take && OP_KIND == OP_ENTER_DEBUG) |=> (DEBUG_ENTER == $past(BG_MODE_EN)))
        else $error("debug entry mismatch");
    AST_SW_TRAP_SEQ: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (take && OP_KIND == OP_SW_TRAP) |=> ##1 STACK_WR [*3] ##1 VECTOR_FETCH)
        else $error("software trap stack sequence broken");
    AST_SW_TRAP_SSP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (take && OP_KIND == OP_SW_TRAP) |-> ##4 (ssp_q == $past(ssp_q, 4) - 32'h0000_0008))
        else $error("stack pointer not lowered by frame size");
    AST_AND_IMM: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (take && OP_KIND == OP_AND_IMM) |=> (flags_q == ($past(flags_q) & $past(imm_flags))))
        else $error("and immediate result wrong");
    AST_FLUSH: assert property (@(posedge REF_CLK) disable iff (!RST_N)
        (take && (OP_KIND == OP_OR_IMM || OP_KIND == OP_SW_TRAP)) |=> FLUSH)
        else $error("pipeline not flushed");

endmodule

`default_nettype wire

//--- breakpoint_instr_model.sv
`timescale 1ns/1ps
`default_nettype none
module breakpoint_instr_model (
    input  wire logic        clk,
    input  wire logic        cycle_on,
    input  wire logic        give,
    input  wire logic [1:0]  lag,
    input  wire logic [15:0] word,
    output logic             ack,
    output logic             noack,
    output logic [15:0]      ack_word
);
    logic [1:0] wait_q;
    // One answer per acknowledge cycle, after 0 to 3 idle cycles
    // Word line shows garbage outside the answer so stale data cannot pass
    always_ff @(posedge clk) begin
        ack      <= 1'b0;
        noack    <= 1'b0;
        ack_word <= ~word;
        wait_q   <= '0;
        if (cycle_on && !ack && !noack) begin
            if (wait_q == lag) begin
                ack      <= give;
                noack    <= !give;
                ack_word <= word;
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb_condition_test_and_trap_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "cond_trap_cfg.svh"
module tb_condition_test_and_trap_logic;
    import cond_trap_pkg::*;
    logic        REF_CLK = 1'b0, RST_N, OP_VALID, BG_MODE_EN, FLAG_WE, SSP_LOAD;
    logic        BREAKPOINT_INSTR_ACK, BREAKPOINT_INSTR_NOACK, BUSY, BREAKPOINT_INSTR_ACK_CYCLE, COND_RESULT, FLUSH, EXC_REQ;
    logic        VECTOR_FETCH, DEBUG_ENTER, EXEC_WORD_VALID, STACK_WR, STACK_LONG, bk_give;
    op_kind_t    OP_KIND;
    size_t       OP_SIZE;
    logic [1:0]  bk_lag;
    logic [3:0]  COND_CODE, PC_ADVANCE;
    logic [4:0]  FLAG_IN, FLAG_REGISTER, fl;
    logic [7:0]  IMM_BYTE, TRAP_NUM, EXC_VECTOR;
    logic [15:0] STATUS_WORD, BREAKPOINT_INSTR_WORD, EXEC_WORD, bk_word;
    logic [31:0] DATA_VAL, LOWER_BOUND, UPPER_BOUND, PC_IN, SSP_IN;
    logic [31:0] SUPERVISOR_STACK_POINTER, STACK_ADDR, STACK_DATA, seed = 32'hdbd99cff;
    int          fail_count = 0, total_checks = 0, cycles = 0;
    op_kind_t    kinds [9] = '{OP_COND_TEST, OP_COND_TRAP, OP_OVF_TRAP, OP_BOUND1, OP_BOUND2,
                               OP_AND_IMM, OP_XOR_IMM, OP_OR_IMM, OP_BRANCH};

    cond_trap_unit i_cond_trap_unit (.*);
    breakpoint_instr_model i_breakpoint_instr_model (.clk(REF_CLK), .cycle_on(BREAKPOINT_INSTR_ACK_CYCLE), .give(bk_give),
        .lag(bk_lag), .word(bk_word), .ack(BREAKPOINT_INSTR_ACK), .noack(BREAKPOINT_INSTR_NOACK), .ack_word(BREAKPOINT_INSTR_WORD));

    always #5 REF_CLK = ~REF_CLK;
    // A hung handshake would otherwise stall the run silently
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        repeat (32) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic cond_exp(input logic [3:0] c, input logic [4:0] f);
        logic n, z, v, k;
        logic [15:0] tbl;
        {n, z, v, k} = f[3:0];
        tbl = {z | (n ^ v), !z & !(n ^ v), n ^ v, !(n ^ v), n, !n, v, !v,
               z, !z, k, !k, k | z, !k & !z, 1'b0, 1'b1};
        return tbl[c];
    endfunction
    // Operand as the unit sees it: byte and word sizes are sign extended
    function automatic logic [31:0] sx(input logic [31:0] x, input logic [1:0] z);
        return z == 2'd1 ? {{24{x[7]}}, x[7:0]} : z == 2'd2 ? {{16{x[15]}}, x[15:0]} : x;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic issue(input op_kind_t k);
        @(posedge REF_CLK);
        OP_KIND  <= k;
        OP_VALID <= 1'b1;
        FLAG_WE  <= 1'b0;
        SSP_LOAD <= 1'b0;
        @(posedge REF_CLK);
        OP_VALID <= 1'b0;
        #1;
    endtask
    task automatic stack_run(input op_kind_t k, input logic [7:0] vec, input logic [31:0] sp);
        logic [31:0] ea [3];
        logic [31:0] ed [3];
        int n;
        int f;
        ea = '{sp - 2, sp - 6, sp - 8};
        ed = '{{22'h0, vec, 2'b00}, PC_IN, {16'h0, STATUS_WORD[15:5], fl}};
        n = 0;
        f = 0;
        @(posedge REF_CLK);
        SSP_LOAD   <= 1'b1;
        SSP_IN     <= sp;
        BG_MODE_EN <= 1'b0;
        issue(k);
        repeat (8) begin
            if (STACK_WR === 1'b1 && n < 3) begin
                check("stack address", STACK_ADDR, ea[n]);
                check("stack data", STACK_DATA, ed[n]);
                check("stack long", STACK_LONG, n == 1);
                check("busy", BUSY, 1'b1);
                n++;
            end
            if (VECTOR_FETCH === 1'b1) begin
                f++;
                check("vector", EXC_VECTOR, vec);
                check("busy", BUSY, 1'b0);
            end
            @(posedge REF_CLK);
            #1;
        end
        check("pushes", n, 3);
        check("fetches", f, 1);
        check("pointer", SUPERVISOR_STACK_POINTER, sp - 8);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] s, d, u, l;
        op_kind_t k;
        logic c, exc;
        logic [7:0] vec;
        int w, t;
        logic [1:0] sz, sb;
        logic [3:0] pa;
        RST_N = 1'b0;
        {OP_VALID, BG_MODE_EN, FLAG_WE, SSP_LOAD, bk_give, bk_lag, bk_word} = '0;
        OP_KIND = OP_NONE;
        OP_SIZE = SZ_LONG;
        {COND_CODE, FLAG_IN, IMM_BYTE, TRAP_NUM} = 25'h0;
        {DATA_VAL, LOWER_BOUND, UPPER_BOUND, SSP_IN, PC_IN} = {128'h0, rnd()};
        STATUS_WORD = 16'ha5c3;
        repeat (8) @(posedge REF_CLK);
        RST_N <= 1'b1;
        for (int i = 0; i < 240; i++) begin
            s = rnd();
            d = rnd();
            u = d + s[13:12] - 1;
            l = d - s[15:14] + 1;
            k = i < 16 ? OP_COND_TEST : kinds[s[27:24] % 9];
            c = cond_exp(i[3:0], s[4:0]);
            sz = s[29:28];
            sb = (sz == 2'd1) ? 2'd2 : sz;
            pa = sz == 2'd3 ? `PC_ADV_LONG : sz == 2'd2 ? `PC_ADV_WORD : `PC_ADV_NONE;
            @(posedge REF_CLK);
            FLAG_WE     <= 1'b1;
            OP_SIZE     <= size_t'(sz);
            FLAG_IN     <= s[4:0];
            COND_CODE   <= i[3:0];
            IMM_BYTE    <= s[23:16];
            DATA_VAL    <= d;
            UPPER_BOUND <= u;
            LOWER_BOUND <= l;
            TRAP_NUM    <= s[31:24];
            issue(k);
            fl = s[4:0];
            {exc, vec} = {1'b0, `VEC_BOUND};
            case (k)
                OP_COND_TRAP: {exc, vec} = {c, `VEC_COND_TRAP};
                OP_OVF_TRAP:  {exc, vec} = {s[`FLAG_V], `VEC_OVF_TRAP};
                OP_BOUND1:    exc = $signed(sx(d, sb)) < 0
                                    || $signed(sx(d, sb)) > $signed(sx(u, sb));
                OP_BOUND2:    exc = $signed(sx(d, sz)) < $signed(sx(l, sz))
                                    || $signed(sx(d, sz)) > $signed(sx(u, sz));
                OP_BRANCH:    {exc, vec} = {i[3:0] == `CODE_NEVER, `VEC_ILLEGAL};
                OP_AND_IMM:   fl = fl & s[20:16];
                OP_XOR_IMM:   fl = fl ^ s[20:16];
                OP_OR_IMM:    fl = fl | s[20:16];
                default:      exc = 1'b0;
            endcase
            check("exception", EXC_REQ, exc);
            if (exc) check("vector", EXC_VECTOR, vec);
            check("flush", FLUSH, !(k inside {OP_COND_TEST, OP_BRANCH}));
            check("flags", FLAG_REGISTER, fl);
            check("condition", COND_RESULT, c);
            check("pc advance", PC_ADVANCE, pa);
        end
        @(posedge REF_CLK);
        BG_MODE_EN <= 1'b1;
        issue(OP_ENTER_DEBUG);
        check("debug entry", DEBUG_ENTER, 1'b1);
        stack_run(OP_ENTER_DEBUG, `VEC_DEBUG, rnd());
        stack_run(OP_SW_TRAP, 8'h20 + s[27:24], rnd());
        for (int j = 0; j < 4; j++) begin
            s = rnd();
            bk_give = j[0];
            bk_lag = {j[0], j[1]};
            bk_word = s[15:0];
            w = 0;
            t = 0;
            issue(OP_BREAKPOINT_INSTR);
            check("ack cycle", BREAKPOINT_INSTR_ACK_CYCLE, 1'b1);
            check("busy", BUSY, 1'b1);
            repeat (10) begin
                if (EXEC_WORD_VALID === 1'b1) begin
                    w++;
                    check("exec word", EXEC_WORD, bk_word);
                end
                t += (EXC_REQ === 1'b1 && EXC_VECTOR === `VEC_ILLEGAL);
                @(posedge REF_CLK);
                #1;
            end
            check("word runs", w, bk_give);
            check("illegal traps", t, !bk_give);
            check("ack cycle", BREAKPOINT_INSTR_ACK_CYCLE, 1'b0);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
